//--- common/rcsr_map.vh
// Register map, field positions and reset values of the reset-cause block.
// Included by the core file; definitions only.
`ifndef RCSR_MAP_VH
`define RCSR_MAP_VH

`define RCSR_OFS_CAUSE      12'h000
`define RCSR_OFS_IRQ_STAT   12'h004
`define RCSR_OFS_IRQ_MASK   12'h008

`define RCSR_BIT_TRAP       15
`define RCSR_BIT_ILLOP      14
`define RCSR_BIT_FLASH_REG  11
`define RCSR_BIT_CFGMIS     9
`define RCSR_BIT_CORE_REG   8
`define RCSR_BIT_EXTPIN     7
`define RCSR_BIT_RSTINS     6
`define RCSR_BIT_WDT_EN     5
`define RCSR_BIT_WATCHDOG_TIMEOUT_FLAG       4
`define RCSR_BIT_SLEEP      3
`define RCSR_BIT_IDLE       2
`define RCSR_BIT_BROWNOUT   1
`define RCSR_BIT_POR        0

`define RCSR_IMPL_MASK      16'hCBFF
`define RCSR_FLAG_MASK      16'hC2D3
`define RCSR_POR_VALUE      16'h0003

`define RCSR_HTRANS_NONSEQ  2'h2
`define RCSR_HTRANS_SEQ     2'h3
`define RCSR_HSIZE_WORD     3'h2

`endif

//--- core/rcsr_top.v
// Reset-cause and sleep regulator control register with AHB-Lite slave.
// Assumes cause pulses are synchronous to i_clk, and that i_nrst is the
// power-on reset only; other resets arrive as cause pulses and keep state.
// Behaviour
// (R01) Trap conflict sets bit 15
// (R02) Illegal opcode or pointer sets bit 14
// (R03) Bit 11 keeps flash regulator on in sleep
// (R04) Configuration mismatch sets bit 9
// (R05) Bit 8 keeps core regulator on in sleep
// (R06) Master clear pin reset sets bit 7
// (R07) Reset instruction sets bit 6
// (R08) Bit 5 enables watchdog by software
// (R09) Watchdog expiry sets bit 4
// (R10) Software may set or clear every flag
// (R11) Software flag writes never cause reset
// (R12) Unprogrammed fuse forces watchdog on always
// (R13) Unimplemented bits read zero, ignore writes
// (R14) Power-on loads 0003, others zero
// (R15) Power-on and brown-out set their flags
// (R16) Flags persist through non power-on resets
`timescale 1ns/1ps
`include "rcsr_map.vh"

module rcsr_top (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_hsel,
  input  wire [11:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output wire        o_hreadyout,
  output wire        o_hresp,
  output reg  [31:0] o_hrdata,
  input  wire        i_trap_conflict,
  input  wire        i_illegal_operation,
  input  wire        i_config_mismatch,
  input  wire        i_master_clear_pin,
  input  wire        i_reset_instruction,
  input  wire        i_watchdog_expired,
  input  wire        i_brownout,
  input  wire        i_power_on_event,
  input  wire        i_watchdog_fuse_enable,
  input  wire        i_in_sleep,
  input  wire        i_in_idle,
  output wire        o_watchdog_enable,
  output wire        o_flash_regulator_standby,
  output wire        o_core_regulator_standby,
  output wire        o_irq
);

  // Register map constants, fixed at the documented layout
  localparam [15:0] IMPL_MASK = `RCSR_IMPL_MASK;
  localparam [15:0] FLAG_MASK = `RCSR_FLAG_MASK;
  localparam [15:0] POR_VALUE = `RCSR_POR_VALUE;
  localparam [11:0] OFS_CAUSE = `RCSR_OFS_CAUSE;
  localparam [11:0] OFS_STAT  = `RCSR_OFS_IRQ_STAT;
  localparam [11:0] OFS_MASK  = `RCSR_OFS_IRQ_MASK;
  localparam [1:0]  TR_NSEQ   = `RCSR_HTRANS_NONSEQ;
  localparam [1:0]  TR_SEQ    = `RCSR_HTRANS_SEQ;

  // Flag and control positions
  localparam integer B_TRAP      = `RCSR_BIT_TRAP;
  localparam integer B_ILLOP     = `RCSR_BIT_ILLOP;
  localparam integer B_FLASH_REG = `RCSR_BIT_FLASH_REG;
  localparam integer B_CFGMIS    = `RCSR_BIT_CFGMIS;
  localparam integer B_CORE_REG  = `RCSR_BIT_CORE_REG;
  localparam integer B_EXTPIN    = `RCSR_BIT_EXTPIN;
  localparam integer B_RSTINS    = `RCSR_BIT_RSTINS;
  localparam integer B_WDT_EN    = `RCSR_BIT_WDT_EN;
  localparam integer B_WATCHDOG_TIMEOUT_FLAG      = `RCSR_BIT_WATCHDOG_TIMEOUT_FLAG;
  localparam integer B_SLEEP     = `RCSR_BIT_SLEEP;
  localparam integer B_IDLE      = `RCSR_BIT_IDLE;
  localparam integer B_BROWNOUT  = `RCSR_BIT_BROWNOUT;
  localparam integer B_POR       = `RCSR_BIT_POR;

  // Assembled register images, one bit per generate entry
  wire [15:0] reset_cause_control;
  wire [15:0] irq_stat;
  wire [15:0] irq_mask;
  wire [15:0] irq_pend;
  wire [15:0] next_cause;
  wire [15:0] next_stat;
  wire [15:0] next_mask;

  // Bus side
  reg         wr_pend;
  reg  [11:0] wr_addr;
  reg  [15:0] next_rdata;
  wire        sel_ok;
  wire        trans_ok;
  wire        acc;
  wire        rd_acc;
  wire        wr_acc;
  wire        rd_load;
  wire        addr_cause;
  wire        addr_stat;
  wire        addr_mask;
  wire        wr_cause;
  wire        wr_stat;
  wire        wr_mask;
  wire [15:0] wdat;

  // Hardware events and power controls
  reg  [15:0] ev_vec;
  wire        wdt_soft;
  wire        flash_keep;
  wire        core_keep;

  // Single-cycle slave: never stalls, always OKAY
  assign o_hreadyout = 1'h1;
  assign o_hresp     = 1'h0;

  // A transfer is taken only with select, ready and an active type
  assign sel_ok   = i_hsel & i_hready;
  assign trans_ok = (i_htrans == TR_NSEQ) | (i_htrans == TR_SEQ);
  assign acc      = sel_ok & trans_ok;
  assign rd_acc   = acc & ~i_hwrite;
  assign wr_acc   = acc & i_hwrite;
  // Read data loads at the edge that takes the address phase
  assign rd_load  = rd_acc;

  // Writes land in the data phase, so decode the captured address
  assign addr_cause = (wr_addr == OFS_CAUSE);
  assign addr_stat  = (wr_addr == OFS_STAT);
  assign addr_mask  = (wr_addr == OFS_MASK);

  assign wr_cause   = wr_pend & addr_cause;
  assign wr_stat    = wr_pend & addr_stat;
  assign wr_mask    = wr_pend & addr_mask;
  // Only the low half word carries register bits
  assign wdat       = i_hwdata[15:0];

  // Write strobe and address wait one cycle for hwdata
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend <= 1'h0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= wr_acc;
      wr_addr <= i_haddr;
    end
  end

  // Hardware cause events, one bit per flag position
  always @* begin
    ev_vec = 16'h0000;

    // (R01) trap conflict
    ev_vec[B_TRAP]     = i_trap_conflict;

    // (R02) illegal operation
    ev_vec[B_ILLOP]    = i_illegal_operation;

    // (R04) config mismatch
    ev_vec[B_CFGMIS]   = i_config_mismatch;

    // (R06) external pin reset
    ev_vec[B_EXTPIN]   = i_master_clear_pin;

    // (R07) reset instruction
    ev_vec[B_RSTINS]   = i_reset_instruction;

    // (R09) watchdog time-out
    ev_vec[B_WATCHDOG_TIMEOUT_FLAG]     = i_watchdog_expired;

    // (R15) brown-out flag
    ev_vec[B_BROWNOUT] = i_brownout;
    // (R15) power-on flag
    ev_vec[B_POR]      = i_power_on_event;

    // Sleep status uses the sticky set path like the cause flags
    ev_vec[B_SLEEP]    = i_in_sleep;
    ev_vec[B_IDLE]     = i_in_idle;
  end

  // Each bit is its own slice, so unused positions cost no flop
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 16; bit_idx = bit_idx + 1) begin : g_bit

      if (IMPL_MASK[bit_idx]) begin : g_impl
        wire hw_set;
        wire sw_load;
        wire keep_val;
        reg  cause_bit;

        assign hw_set  = ev_vec[bit_idx];
        assign sw_load = wr_cause;
        // (R10) software writes either value
        assign keep_val = sw_load ? wdat[bit_idx] : cause_bit;
        // Hardware set wins over a same-cycle software clear
        assign next_cause[bit_idx] = keep_val | hw_set;

        // (R14) power-on defaults
        always @(posedge i_clk or negedge i_nrst) begin
          if (!i_nrst) begin
            cause_bit <= POR_VALUE[bit_idx];
          end else begin
            // (R16) held until event or write
            cause_bit <= next_cause[bit_idx];
          end
        end
        assign reset_cause_control[bit_idx] = cause_bit;
      end else begin : g_unimpl
        // (R13) unimplemented bits read zero
        // No flop is built, so writes cannot reach these bits
        assign next_cause[bit_idx]          = 1'h0;
        assign reset_cause_control[bit_idx] = 1'h0;
      end

      // Status and mask exist only at cause flag positions
      if (FLAG_MASK[bit_idx]) begin : g_flag
        wire stat_set;
        wire stat_clr;
        reg  stat_bit;
        reg  mask_bit;

        assign stat_set = ev_vec[bit_idx];
        assign stat_clr = wr_stat & wdat[bit_idx];
        // Set wins over a same-cycle write-one clear
        assign next_stat[bit_idx] = stat_set | (stat_bit & ~stat_clr);
        assign next_mask[bit_idx] = wr_mask ? wdat[bit_idx] : mask_bit;

        always @(posedge i_clk or negedge i_nrst) begin
          if (!i_nrst) begin
            stat_bit <= 1'h0;
          end else begin
            stat_bit <= next_stat[bit_idx];
          end
        end

        // Mask follows the status layout
        always @(posedge i_clk or negedge i_nrst) begin
          if (!i_nrst) begin
            mask_bit <= 1'h0;
          end else begin
            mask_bit <= next_mask[bit_idx];
          end
        end

        assign irq_stat[bit_idx] = stat_bit;
        assign irq_mask[bit_idx] = mask_bit;
      end else begin : g_noflag
        // Positions that are not cause flags never interrupt
        assign next_stat[bit_idx] = 1'h0;
        assign next_mask[bit_idx] = 1'h0;
        assign irq_stat[bit_idx]  = 1'h0;
        assign irq_mask[bit_idx]  = 1'h0;
      end

    end
  endgenerate

  // Cause and status reads return next state so a read right after a write sees it; mask reads return the stored mask
  always @* begin
    case (i_haddr)
      OFS_CAUSE: begin
        next_rdata = next_cause;
      end
      OFS_STAT: begin
        next_rdata = next_stat;
      end
      OFS_MASK: begin
        next_rdata = irq_mask;
      end
      default: begin
        // Unmapped offsets read zero
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data holds until the next read address phase
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h00000000;
    end else if (rd_load) begin
      o_hrdata <= {16'h0000, next_rdata};
    end
  end

  // Level interrupt from any unmasked sticky status bit
  assign irq_pend = irq_stat & irq_mask;
  assign o_irq    = |irq_pend;

  // (R08) software watchdog enable
  assign wdt_soft = reset_cause_control[B_WDT_EN];
  // (R12) unprogrammed fuse forces on
  assign o_watchdog_enable = i_watchdog_fuse_enable | wdt_soft;

  // Regulator keep bits only matter while the core sleeps
  assign flash_keep = reset_cause_control[B_FLASH_REG];
  assign core_keep  = reset_cause_control[B_CORE_REG];
  // (R03) flash standby unless kept
  assign o_flash_regulator_standby = i_in_sleep & ~flash_keep;
  // (R05) core standby unless kept
  assign o_core_regulator_standby  = i_in_sleep & ~core_keep;

  // (R11) flag writes only store bits
  // No reset request output exists, so a write can never reset the device
endmodule

//--- test/rcsr_asserts.sv
// Checker for the reset-cause block, bound to its top module.
// Sees top ports only; one clock, power-on reset only.
`timescale 1ns/1ps
module rcsr_asserts (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_watchdog_fuse_enable,
  input wire logic        i_in_sleep,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_watchdog_enable,
  input wire logic        o_flash_regulator_standby,
  input wire logic        o_core_regulator_standby
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire rd_ph = i_hsel && i_htrans[1] && !i_hwrite;
  wire wr_ph = i_hsel && i_htrans[1] && i_hwrite;
  property p_ok; o_hreadyout && !o_hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready");
  property p_zero; (o_hrdata & 32'hFFFF3400) == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_fuse; i_watchdog_fuse_enable |-> o_watchdog_enable; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse ignored");
  property p_fsb; o_flash_regulator_standby |-> i_in_sleep; endproperty
  a_fsb: assert property (p_fsb) else $error("flash standby awake");
  property p_csb; o_core_regulator_standby |-> i_in_sleep; endproperty
  a_csb: assert property (p_csb) else $error("core standby awake");
  property p_hold; !$past(rd_ph) |-> $stable(o_hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wdt;
    $changed(o_watchdog_enable) && $stable(i_watchdog_fuse_enable) |-> $past(wr_ph, 2);
  endproperty
  a_wdt: assert property (p_wdt) else $error("enable moved alone");
  property p_sb;
    $changed(o_core_regulator_standby) |-> $changed(i_in_sleep) || $past(wr_ph, 2);
  endproperty
  a_sb: assert property (p_sb) else $error("standby moved alone");
endmodule
bind rcsr_top rcsr_asserts rcsr_asserts_inst (.*);

//--- test/reset_cause_status_register_bench.sv
// Bench for the reset-cause block: bus traffic and cause pulses.
// Assumes a zero-wait slave; pulses last one clock.
`timescale 1ns/1ps
module reset_cause_status_register_bench;
  reg i_clk = 0, i_nrst = 0, hsel = 0, hw = 0, fuse = 0, slp = 0, idl = 0;
  reg [11:0] ha = 0;
  reg [1:0]  ht = 0;
  reg [7:0]  ev = 0;
  reg [31:0] wd = 0, q, e;
  wire rdy, resp, wdt, fsb, csb, irq;
  wire [31:0] rd;
  int bad_count = 0, n_compared = 0, p[8] = '{0, 1, 4, 6, 7, 9, 14, 15};
  rcsr_top rcsr_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(ha),
    .i_htrans(ht), .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(wd), .i_hready(rdy),
    .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(rd), .i_trap_conflict(ev[7]),
    .i_illegal_operation(ev[6]), .i_config_mismatch(ev[5]), .i_master_clear_pin(ev[4]),
    .i_reset_instruction(ev[3]), .i_watchdog_expired(ev[2]), .i_brownout(ev[1]),
    .i_power_on_event(ev[0]), .i_watchdog_fuse_enable(fuse), .i_in_sleep(slp),
    .i_in_idle(idl), .o_watchdog_enable(wdt), .o_flash_regulator_standby(fsb),
    .o_core_regulator_standby(csb), .o_irq(irq));
  task chk(input [31:0] s, input [31:0] x);
    n_compared++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge i_clk);
    {hsel, hw, ha, ht} <= {1'h1, w, a, 2'h2};
    do @(posedge i_clk); while (rdy !== 1'h1);
    {hsel, ht, wd} <= {1'h0, 2'h0, d};
    do @(posedge i_clk); while (rdy !== 1'h1);
    q = rd;
    #1;
  endtask
  task pulse(input [7:0] v);
    @(posedge i_clk);
    ev <= v;
    @(posedge i_clk);
    ev <= 8'h00;
    @(posedge i_clk);
    #1;
  endtask
  task t_bits;
    bus(0, 12'h000, 0);
    chk(q, 32'h0003);
    bus(1, 12'h000, 32'hFFFFFFFF);
    bus(0, 12'h000, 0);
    chk(q, 32'hCBFF);
    bus(1, 12'h000, 0);
    bus(0, 12'h00C, 0);
    chk(q, 0);
  endtask
  task t_ev;
    e = 0;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      e[p[i]] = 1'h1;
      bus(0, 12'h000, 0);
      chk(q, e);
    end
  endtask
  task t_pwr;
    slp <= 1;
    idl <= 1;
    bus(1, 12'h000, 32'h0920);
    chk({wdt, fsb, csb}, 3'h4);
    bus(1, 12'h000, 0);
    chk({wdt, fsb, csb}, 3'h3);
    bus(0, 12'h000, 0);
    chk(q, 32'h000C);
    fuse <= 1;
    pulse(0);
    chk(wdt, 1);
    fuse <= 0;
    slp <= 0;
    idl <= 0;
  endtask
  task t_irq;
    bus(1, 12'h004, 32'hFFFF);
    bus(1, 12'h008, 32'h8000);
    pulse(8'h40);
    chk(irq, 0);
    pulse(8'h80);
    chk(irq, 1);
    bus(1, 12'h004, 32'h8000);
    chk(irq, 0);
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #5 i_clk = ~i_clk;
  initial begin
    #100000;
    bad_count++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1;
    t_bits;
    t_ev;
    t_pwr;
    t_irq;
    summarize;
  end
endmodule
